/* verilog/ect_pkg.sv */
package ect_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFF_COUNTER = 8'h00;
   localparam logic [7:0] OFF_CONST_A = 8'h04;
   localparam logic [7:0] OFF_CONST_B = 8'h08;
   localparam logic [7:0] OFF_CTRL0 = 8'h0c;
   localparam logic [7:0] OFF_FLAGS = 8'h10;
   localparam logic [7:0] OFF_CTRL1 = 8'h14;

   // values after reset, and the top count before overflow
   localparam logic [7:0] RST_COUNTER = 8'h00;
   localparam logic [7:0] RST_CONST = 8'hff;
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h10;
   localparam logic [7:0] RST_CTRL1 = 8'he2;
   localparam logic [7:0] COUNTER_TOP = 8'hff;

   // field positions in the flag/output-select register
   localparam int POS_FLAG_B = 7;
   localparam int POS_FLAG_A = 6;
   localparam int POS_FLAG_OVF = 5;
   localparam int POS_RSVD_FLAGS = 4;
   // field positions in the trigger/clock-select register
   localparam int POS_TRIG_EDGE = 3;
   localparam int POS_TRIG_EN = 2;
   localparam int POS_INT_CLK = 0;
   localparam logic [7:0] CTRL1_RSVD_ONES = 8'he2;

   // two-bit selector codes shared by output action, edge and clear select
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_ONE = 2'h1;
   localparam logic [1:0] SEL_TWO = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // clock-select codes
   localparam logic [2:0] CKS_OFF_LO = 3'h0;
   localparam logic [2:0] CKS_OFF_HI = 3'h4;
   localparam logic [2:0] CKS_EXT_RISE = 3'h5;
   localparam logic [2:0] CKS_EXT_FALL = 3'h6;
   localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

   typedef struct packed {
      logic match_b_irq_enable;
      logic match_a_irq_enable;
      logic overflow_irq_enable;
      logic [1:0] clear_sel;
      logic [2:0] clock_sel;
   } ect_ctrl0_type;

   typedef enum logic {ect_running, ect_halted} ect_run_type;
endpackage

/* verilog/ect_timer.sv */
module ect_timer #(
   parameter int PRESCALE_BITS = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby_mode,
   input wire logic watch_sub_mode,
   input wire logic trigger_pin,
   input wire logic external_clear_pin,
   input wire logic external_clock_pin,
   output logic timer_out_pin,
   output logic match_a_irq,
   output logic match_b_irq,
   output logic overflow_irq,
   output logic timer_irq
);
   initial begin
      if (PRESCALE_BITS < 7)
         $error("prescaler must reach divide by 128");
   end

   // registers
   logic [7:0] up_counter;
   logic [7:0] time_constant_a;
   logic [7:0] time_constant_b;
   ect_pkg::ect_ctrl0_type clear_clock_irq_control;
   logic match_b_flag;
   logic match_a_flag;
   logic overflow_flag;
   logic [3:0] output_select;
   logic [1:0] trigger_edge;
   logic trigger_enable;
   logic internal_clock_sel;
   logic [2:0] flag_armed;
   ect_pkg::ect_run_type run_state;
   logic [PRESCALE_BITS-1:0] prescaler;
   logic clock_level_prev;
   logic trigger_prev;
   logic clear_pin_prev;

   // bus decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready;
   wire bus_write = access_done & pwrite;
   wire bus_read = access_done & ~pwrite;
   wire hit_counter = paddr == ect_pkg::OFF_COUNTER;
   wire hit_const_a = paddr == ect_pkg::OFF_CONST_A;
   wire hit_const_b = paddr == ect_pkg::OFF_CONST_B;
   wire hit_ctrl0 = paddr == ect_pkg::OFF_CTRL0;
   wire hit_flags = paddr == ect_pkg::OFF_FLAGS;
   wire hit_ctrl1 = paddr == ect_pkg::OFF_CTRL1;
   wire mapped = hit_counter | hit_const_a | hit_const_b | hit_ctrl0 |
      hit_flags | hit_ctrl1;
   wire wr_counter = bus_write & hit_counter;
   wire wr_const_a = bus_write & hit_const_a;
   wire wr_const_b = bus_write & hit_const_b;
   wire wr_ctrl0 = bus_write & hit_ctrl0;
   wire wr_flags = bus_write & hit_flags;
   wire wr_ctrl1 = bus_write & hit_ctrl1;
   wire rd_flags = bus_read & hit_flags;
   wire [7:0] wbyte = pwdata[7:0];

   // low-power modes act as a synchronous reset; control reg 1 survives standby
   wire lp_all = standby_mode | watch_sub_mode;
   wire lp_ctrl1 = watch_sub_mode;

   // read views
   wire [2:0] flag_bits = {match_b_flag, match_a_flag, overflow_flag};
   wire [7:0] flags_view = {flag_bits, 1'b1, output_select};
   wire [7:0] ctrl1_view = ect_pkg::CTRL1_RSVD_ONES |
      {3'h0, trigger_edge, trigger_enable, 1'b0, internal_clock_sel};
   wire [7:0] read_mux =
      hit_counter ? up_counter :
      hit_const_a ? time_constant_a :
      hit_const_b ? time_constant_b :
      hit_ctrl0 ? clear_clock_irq_control :
      hit_flags ? flags_view :
      hit_ctrl1 ? ctrl1_view : 8'h00;

   // index of the prescaler bit whose falling edge gives the division
   function automatic logic [2:0] divider_tap(input logic [1:0] cks_lo,
                                              input logic icks);
      logic [3:0] t;
      t = {1'b0, cks_lo, 1'b0} + {3'h0, icks} - 4'h1;
      divider_tap = t[2:0];
   endfunction

   // edge pick from a two-bit selector: one = rising, two = falling
   function automatic logic edge_pick(input logic [1:0] sel,
                                      input logic prev, input logic now);
      case (sel)
         ect_pkg::SEL_ONE: edge_pick = ~prev & now;
         ect_pkg::SEL_TWO: edge_pick = prev & ~now;
         ect_pkg::SEL_BOTH: edge_pick = prev ^ now;
         default: edge_pick = 1'b0;
      endcase
   endfunction

   // clock source; the level is remembered, so a source switch can count
   wire [2:0] cks = clear_clock_irq_control.clock_sel;
   wire ext_sel = cks[2] & (cks != ect_pkg::CKS_OFF_HI);
   wire int_sel = ~cks[2] & (cks != ect_pkg::CKS_OFF_LO);
   wire [2:0] tap = divider_tap(cks[1:0], internal_clock_sel);
   wire int_level = int_sel & prescaler[tap];
   wire clock_level = ext_sel ? external_clock_pin : int_level;
   wire int_tick = int_sel & clock_level_prev & ~int_level;
   // the selector low bits map straight onto rise/fall/both
   wire ext_tick = ext_sel & edge_pick(cks[1:0], clock_level_prev,
      external_clock_pin);
   wire count_tick = int_tick | ext_tick;

   // run control for triggered mode
   wire counting = ~trigger_enable | (run_state == ect_pkg::ect_running);
   wire advance = count_tick & counting;
   wire trig_edge = edge_pick(trigger_edge, trigger_prev, trigger_pin);

   // matches fire as the counter leaves the equal value; a constant write
   // in the same cycle wins and suppresses the match
   wire match_a = advance & (up_counter == time_constant_a) &
      ~wr_const_a;
   wire match_b = advance & (up_counter == time_constant_b) &
      ~wr_const_b;
   wire clear_pin_rise = ~clear_pin_prev & external_clear_pin;
   wire [1:0] csel = clear_clock_irq_control.clear_sel;
   wire clear_event = ((csel == ect_pkg::SEL_ONE) & match_a) |
      ((csel == ect_pkg::SEL_TWO) & match_b) |
      ((csel == ect_pkg::SEL_BOTH) & clear_pin_rise);
   wire overflow = advance & (up_counter == ect_pkg::COUNTER_TOP) &
      ~clear_event & ~wr_counter;

   // clear beats a counter write, a write beats an increment
   wire [7:0] next_up_counter =
      clear_event ? ect_pkg::RST_COUNTER :
      wr_counter ? wbyte :
      advance ? up_counter + 8'h01 : up_counter;

   // flags: set wins over clear; clear needs a prior read of 1
   wire [2:0] flag_set = {match_b, match_a, overflow};
   wire [2:0] flag_clr = {3{wr_flags}} & ~wbyte[7:5] & flag_armed;
   wire [2:0] next_flags = flag_set | (flag_bits & ~flag_clr);
   wire [2:0] next_armed = (rd_flags ? flag_bits : 3'h0) |
      (flag_armed & ~flag_clr & ~flag_set);

   function automatic logic [1:0] resolve(input logic [1:0] a,
                                          input logic [1:0] b);
      if (a == ect_pkg::SEL_BOTH || b == ect_pkg::SEL_BOTH)
         resolve = ect_pkg::SEL_BOTH;
      else if (a == ect_pkg::SEL_TWO || b == ect_pkg::SEL_TWO)
         resolve = ect_pkg::SEL_TWO;
      else if (a == ect_pkg::SEL_ONE || b == ect_pkg::SEL_ONE)
         resolve = ect_pkg::SEL_ONE;
      else
         resolve = ect_pkg::SEL_NONE;
   endfunction

   wire [1:0] act_a = match_a ? output_select[1:0] : ect_pkg::SEL_NONE;
   wire [1:0] act_b = match_b ? output_select[3:2] : ect_pkg::SEL_NONE;
   wire [1:0] out_action = resolve(act_a, act_b);
   wire next_timer_out =
      (out_action == ect_pkg::SEL_BOTH) ? ~timer_out_pin :
      (out_action == ect_pkg::SEL_TWO) ? 1'b1 :
      (out_action == ect_pkg::SEL_ONE) ? 1'b0 : timer_out_pin;

   // halting on the trigger-enable write itself keeps a 0-to-1 set stopped
   wire trig_arm = wr_ctrl1 & wbyte[ect_pkg::POS_TRIG_EN] & ~trigger_enable;
   wire next_trigger_enable = wr_ctrl1 ? wbyte[ect_pkg::POS_TRIG_EN] :
      trigger_enable;
   ect_pkg::ect_run_type next_run_state;
   always_comb begin
      case (run_state)
         ect_pkg::ect_running: begin
            if (trig_arm || (trigger_enable && clear_event))
               next_run_state = ect_pkg::ect_halted;
            else
               next_run_state = ect_pkg::ect_running;
         end
         ect_pkg::ect_halted: begin
            if (trigger_enable && trig_edge && !clear_event)
               next_run_state = ect_pkg::ect_running;
            else
               next_run_state = ect_pkg::ect_halted;
         end
         default: next_run_state = ect_pkg::ect_running;
      endcase
   end

   ect_pkg::ect_ctrl0_type ctrl0_now;
   assign ctrl0_now = lp_all ? ect_pkg::ect_ctrl0_type'(ect_pkg::RST_CTRL0) :
      clear_clock_irq_control;
   wire [2:0] irq_en = {ctrl0_now.match_b_irq_enable,
      ctrl0_now.match_a_irq_enable, ctrl0_now.overflow_irq_enable};
   wire [2:0] flags_now = lp_all ? 3'h0 : next_flags;
   wire [2:0] next_irq = flags_now & irq_en;

   // bus slave: one wait-free access phase, answer registered at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         prdata <= (setup_phase & ~pwrite) ? {24'h0, read_mux} : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler <= '0;
         clock_level_prev <= 1'b0;
         trigger_prev <= 1'b0;
         clear_pin_prev <= 1'b0;
      end else begin
         prescaler <= prescaler + 1'b1;
         clock_level_prev <= clock_level;
         trigger_prev <= trigger_pin;
         clear_pin_prev <= external_clear_pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_counter <= ect_pkg::RST_COUNTER;
         time_constant_a <= ect_pkg::RST_CONST;
         time_constant_b <= ect_pkg::RST_CONST;
         clear_clock_irq_control <= ect_pkg::RST_CTRL0;
      end else if (lp_all) begin
         up_counter <= ect_pkg::RST_COUNTER;
         time_constant_a <= ect_pkg::RST_CONST;
         time_constant_b <= ect_pkg::RST_CONST;
         clear_clock_irq_control <= ect_pkg::RST_CTRL0;
      end else begin
         up_counter <= next_up_counter;
         time_constant_a <= wr_const_a ? wbyte : time_constant_a;
         time_constant_b <= wr_const_b ? wbyte : time_constant_b;
         if (wr_ctrl0)
            clear_clock_irq_control <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {match_b_flag, match_a_flag, overflow_flag} <= 3'h0;
         output_select <= ect_pkg::RST_FLAGS[3:0];
         flag_armed <= 3'h0;
         timer_out_pin <= 1'b0;
      end else if (lp_all) begin
         {match_b_flag, match_a_flag, overflow_flag} <= 3'h0;
         output_select <= ect_pkg::RST_FLAGS[3:0];
         flag_armed <= 3'h0;
         timer_out_pin <= 1'b0;
      end else begin
         {match_b_flag, match_a_flag, overflow_flag} <= next_flags;
         output_select <= wr_flags ? wbyte[3:0] : output_select;
         flag_armed <= next_armed;
         timer_out_pin <= next_timer_out;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_edge <= ect_pkg::RST_CTRL1[4:3];
         trigger_enable <= ect_pkg::RST_CTRL1[ect_pkg::POS_TRIG_EN];
         internal_clock_sel <= ect_pkg::RST_CTRL1[ect_pkg::POS_INT_CLK];
         run_state <= ect_pkg::ect_running;
      end else if (lp_ctrl1) begin
         trigger_edge <= ect_pkg::RST_CTRL1[4:3];
         trigger_enable <= ect_pkg::RST_CTRL1[ect_pkg::POS_TRIG_EN];
         internal_clock_sel <= ect_pkg::RST_CTRL1[ect_pkg::POS_INT_CLK];
         run_state <= ect_pkg::ect_running;
      end else begin
         if (wr_ctrl1)
            trigger_edge <= wbyte[4:3];
         trigger_enable <= next_trigger_enable;
         if (wr_ctrl1)
            internal_clock_sel <= wbyte[ect_pkg::POS_INT_CLK];
         run_state <= next_run_state;
      end
   end

   // request lines follow flag and enable; the shared line merges all three
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {match_b_irq, match_a_irq, overflow_irq} <= 3'h0;
         timer_irq <= 1'b0;
      end else begin
         {match_b_irq, match_a_irq, overflow_irq} <= next_irq;
         timer_irq <= |next_irq;
      end
   end

   // checks
   sequence flag_a_read_s;
      rd_flags && match_a_flag && !lp_all;
   endsequence
   sequence flag_a_clear_s;
      wr_flags && !wbyte[ect_pkg::POS_FLAG_A] && flag_armed[1] &&
         !match_a && !lp_all;
   endsequence

   flag_a_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_a && !lp_all |=> match_a_flag)
      else $error("match A did not set its flag");
   flag_b_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_b && !lp_all |=> match_b_flag)
      else $error("match B did not set its flag");
   ovf_wraps_a: assert property (@(posedge pclk) disable iff (!presetn)
      overflow && !lp_all |=> overflow_flag && up_counter == 8'h00)
      else $error("overflow did not wrap and flag");
   no_sw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      !match_a_flag && !match_a |=> !match_a_flag)
      else $error("flag A rose without a match");
   clear_unarmed_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_flags && !wbyte[7] && match_b_flag && !flag_armed[2] && !lp_all
      |=> match_b_flag)
      else $error("flag B cleared without a prior read");
   rsvd_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_flags
      |=> prdata[ect_pkg::POS_RSVD_FLAGS])
      else $error("reserved flag bit did not read as one");
   rsvd_ctrl1_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && hit_ctrl1
      |=> (prdata[7:0] & ect_pkg::CTRL1_RSVD_ONES) ==
      ect_pkg::CTRL1_RSVD_ONES)
      else $error("reserved trigger bits did not read as one");
   toggle_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_a && output_select[1:0] == 2'h3 && !lp_all
      |=> timer_out_pin != $past(timer_out_pin))
      else $error("output did not toggle on match");
   idle_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      output_select == 4'h0 && !lp_all |=> $stable(timer_out_pin))
      else $error("output moved with selects at zero");
   clear_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
      clear_event && trigger_enable && !lp_all
      |=> up_counter == 8'h00 && run_state == ect_pkg::ect_halted)
      else $error("clear did not zero and halt the counter");
   halted_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      trigger_enable && run_state == ect_pkg::ect_halted && !wr_counter &&
      !clear_event && !lp_all |=> $stable(up_counter))
      else $error("halted counter moved");
   // an enable write shows on the request one edge late, so skip that edge
   irq_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_ctrl0 |=> timer_irq ==
      |({match_b_flag, match_a_flag, overflow_flag} &
      {clear_clock_irq_control.match_b_irq_enable,
      clear_clock_irq_control.match_a_irq_enable,
      clear_clock_irq_control.overflow_irq_enable}))
      else $error("shared request disagrees with sources");
   arm_on_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      flag_a_read_s |=> flag_armed[1])
      else $error("reading flag A as one did not arm its clear");
   read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      flag_a_clear_s |=> !match_a_flag)
      else $error("armed clear of flag A failed");
endmodule

/* sim/ect_pins_model.sv */
module ect_pins_model (
   input wire logic pclk,
   output logic trigger_pin,
   output logic external_clear_pin,
   output logic external_clock_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lines = 3'h0;
   // every line idles low between pulses; the count clock never runs free
   assign {trigger_pin, external_clear_pin, external_clock_pin} = lines;
   // idx 0 count clock, 1 clear pin, 2 trigger pin
   // 3 cycles high and 3 low keep clear of the both-edge minimum width
   task automatic pulse(input int idx);
      @(posedge pclk);
      lines[idx] <= 1'b1;
      repeat (3) @(posedge pclk);
      lines[idx] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule

/* sim/ect_timer_tb.sv */
module ect_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_CNT = ect_pkg::OFF_COUNTER;
   localparam logic [7:0] A_CA = ect_pkg::OFF_CONST_A;
   localparam logic [7:0] A_CB = ect_pkg::OFF_CONST_B;
   localparam logic [7:0] A_C0 = ect_pkg::OFF_CTRL0;
   localparam logic [7:0] A_FLG = ect_pkg::OFF_FLAGS;
   localparam logic [7:0] A_TRG = ect_pkg::OFF_CTRL1;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, standby_mode, watch_sub_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, trigger_pin, external_clear_pin;
   logic external_clock_pin, timer_out_pin, pin_exp;
   logic match_a_irq, match_b_irq, overflow_irq, timer_irq;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

   always #12.5 pclk = ~pclk;

   ect_timer u_ect_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby_mode(standby_mode), .watch_sub_mode(watch_sub_mode),
      .trigger_pin(trigger_pin), .external_clear_pin(external_clear_pin),
      .external_clock_pin(external_clock_pin),
      .timer_out_pin(timer_out_pin), .match_a_irq(match_a_irq),
      .match_b_irq(match_b_irq), .overflow_irq(overflow_irq),
      .timer_irq(timer_irq));
   ect_pins_model u_ect_pins_model (.pclk(pclk),
      .trigger_pin(trigger_pin), .external_clear_pin(external_clear_pin),
      .external_clock_pin(external_clock_pin));

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // cuts a hung handshake short
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic chk(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t ns: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one idle cycle ahead of each setup so no signal is assigned twice
   task automatic apb(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      // upper lanes carry noise that the slave must ignore
      pwdata <= {24'h5a3c96, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, exp);
      logic [7:0] q;
      logic e;
      apb(1'b0, a, 8'h00, q, e);
      chk(q, exp, "read");
   endtask

   task automatic pins(input logic [4:0] exp);
      chk({3'h0, timer_out_pin, match_b_irq, match_a_irq, overflow_irq,
          timer_irq}, {3'h0, exp}, "pins");
   endtask

   initial begin
      logic [7:0] q;
      logic e;
      {psel, penable, pwrite, standby_mode, watch_sub_mode} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      pins(5'h00);
      rd(A_CNT, 8'h00);
      rd(A_CA, 8'hff);
      rd(A_CB, 8'hff);
      rd(A_C0, 8'h00);
      rd(A_FLG, 8'h10);
      rd(A_TRG, 8'he2);
      wr(A_FLG, 8'hef);
      rd(A_FLG, 8'h1f);
      wr(A_TRG, 8'h01);
      rd(A_TRG, 8'he3);
      standby_mode <= 1'b1;
      rd(A_FLG, 8'h10);
      rd(A_TRG, 8'he3);
      standby_mode <= 1'b0;
      watch_sub_mode <= 1'b1;
      rd(A_TRG, 8'he2);
      watch_sub_mode <= 1'b0;
      apb(1'b0, 8'h18, 8'h00, q, e);
      chk({e, q[6:0]}, 8'h80, "unmapped");
      $display("test registers done");
      for (int k = 5; k < 8; k++) begin
         wr(A_C0, 8'(k));
         wr(A_CNT, 8'h00);
         repeat (2) u_ect_pins_model.pulse(0);
         rd(A_CNT, (k == 7) ? 8'h04 : 8'h02);
      end
      wr(A_C0, 8'h25);
      wr(A_CNT, 8'hff);
      u_ect_pins_model.pulse(0);
      rd(A_CNT, 8'h00);
      rd(A_FLG, 8'hf0);
      pins(5'h03);
      wr(A_FLG, 8'h00);
      rd(A_FLG, 8'h10);
      pins(5'h00);
      $display("test external clock done");
      wr(A_CA, 8'h02);
      wr(A_CB, 8'h02);
      wr(A_C0, 8'h05);
      pin_exp = 1'b0;
      for (int i = 0; i < 16; i++) begin
         wr(A_FLG, 8'(i));
         wr(A_CNT, 8'h02);
         u_ect_pins_model.pulse(0);
         if (i[3:2] == 2'h3 || i[1:0] == 2'h3)
            pin_exp = ~pin_exp;
         else if (i[3:2] == 2'h2 || i[1:0] == 2'h2)
            pin_exp = 1'b1;
         else if (i[3:2] == 2'h1 || i[1:0] == 2'h1)
            pin_exp = 1'b0;
         pins({pin_exp, 4'h0});
      end
      rd(A_FLG, 8'hdf);
      wr(A_C0, 8'h85);
      rd(A_C0, 8'h85);
      pins({pin_exp, 4'h9});
      $display("test output actions done");
      wr(A_FLG, 8'h00);
      wr(A_CA, 8'h01);
      wr(A_C0, 8'h4d);
      for (int t = 0; t < 4; t++) begin
         wr(A_TRG, 8'h00);
         wr(A_TRG, 8'(t * 8 + 4));
         wr(A_CNT, 8'h00);
         u_ect_pins_model.pulse(0);
         rd(A_CNT, 8'h00);
         u_ect_pins_model.pulse(2);
         u_ect_pins_model.pulse(0);
         rd(A_CNT, (t == 0) ? 8'h00 : 8'h01);
      end
      repeat (2) u_ect_pins_model.pulse(0);
      rd(A_CNT, 8'h00);
      pins({pin_exp, 4'h5});
      wr(A_TRG, 8'h00);
      wr(A_CNT, 8'h00);
      repeat (3) u_ect_pins_model.pulse(0);
      rd(A_CNT, 8'h01);
      wr(A_C0, 8'h1d);
      wr(A_CNT, 8'h05);
      u_ect_pins_model.pulse(1);
      rd(A_CNT, 8'h00);
      wr(A_C0, 8'h15);
      wr(A_CNT, 8'h02);
      u_ect_pins_model.pulse(0);
      rd(A_CNT, 8'h00);
      wr(A_C0, 8'h04);
      u_ect_pins_model.pulse(0);
      rd(A_CNT, 8'h00);
      $display("test trigger and clear done");
      // a source switch may add one count at either end of the window
      for (int k = 0; k < 6; k++) begin
         wr(A_C0, 8'h00);
         wr(A_TRG, 8'(k % 2));
         wr(A_CNT, 8'h00);
         wr(A_C0, 8'(k / 2 + 1));
         repeat (16 << (k + 2)) @(posedge pclk);
         wr(A_C0, 8'h00);
         apb(1'b0, A_CNT, 8'h00, q, e);
         chk({7'h0, q inside {[8'd15:8'd18]}}, 8'h01, "prescale");
      end
      $display("test prescaler done");
      final_report();
   end
endmodule
